// file: hdl/suote_pkg.sv
// constants shared by the serial channel and its bit-rate generator
// assumes a single core clock; all control bits arrive as plain ports
`default_nettype none
package suote_pkg;
  localparam logic [2:0] MODE_TW    = 3'h2;
  localparam logic [2:0] MODE_U7    = 3'h4;
  localparam logic [2:0] MODE_U8    = 3'h5;
  localparam logic [2:0] MODE_U9    = 3'h6;
  localparam logic [3:0] LEN7       = 4'h7;
  localparam logic [3:0] LEN8       = 4'h8;
  localparam logic [3:0] LEN9       = 4'h9;
  localparam logic [3:0] FRAME_XTRA = 4'h2;
  localparam logic [3:0] SUB_LAST   = 4'hf;
  localparam logic [3:0] SUB_MID    = 4'h7;
  localparam logic [2:0] PRE8_LAST  = 3'h7;
  localparam logic [3:0] TW_ACK_BIT = 4'h8;
  localparam logic [3:0] DLY_BASE   = 4'h1;
  localparam logic [7:0] TW_IDLE_TX = 8'hff;
  localparam int         FRAME_W    = 11;

  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } suote_rx_state_t;
endpackage
`default_nettype wire

// file: hdl/suote_baud.sv
// bit-rate generator: count source prescaler and divisor counter
// assumes divisor is held stable while a frame is in flight
`default_nettype none
module suote_baud
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       src_sel,
  input  wire logic [7:0] divisor,
  output logic            src_tick,
  output logic            os_tick
);
  logic [2:0] pre_r;
  logic [7:0] div_r;
  logic       src_nxt;

  // count source is either the core clock or the core clock divided by eight
  assign src_nxt = src_sel ? (pre_r == suote_pkg::PRE8_LAST) : 1'b1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_r <= 3'h0;
    else
      pre_r <= pre_r + 3'h1;
  end

  // divide by divisor plus one, giving sixteen ticks per bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r    <= 8'h00;
      src_tick <= 1'b0;
      os_tick  <= 1'b0;
    end
    else
    begin
      src_tick <= src_nxt;
      os_tick  <= 1'b0;
      if (src_nxt)
      begin
        if (div_r == 8'h00)
        begin
          div_r   <= divisor; // [R1]
          os_tick <= 1'b1;    // [R1]
        end
        else
          div_r <= div_r - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/suote_uart.sv
// serial channel: asynchronous frames of 7/8/9 bits and a simple two-wire mode
// assumes synchronous pin inputs; the far party drives SCL in two-wire mode
// Behaviour
// [R1] bit rate is source over divisor, over sixteen; the code divides by divisor plus one
// [R2] bit order selectable for eight-bit frames
// [R3] transmitted data complemented when invert set; the code leaves 9-bit data uncomplemented
// [R4] received data stored complemented when invert set; the code leaves 9-bit data uncomplemented
// [R5] pin polarity inverts whole line incl. framing
// [R6] two-wire only with mode 010 and enable
// [R7] SDA changes only after SCL low, delayed
// [R8] events: start, stop, ack, missing ack
// [R9] arbitration lost flag, selectable update moment
// [R10] SDA delay none or 2 to 8 cycles
// [R11] clock phase selectable: delayed or not
// [R12] mode picks 7, 8 or 9 data bits
// [R13] one polarity bit for transmit and receive
// [R14] software keeps order default for 7/9 bits
// [R15] receiver samples mid of sixteen sub-periods
`default_nettype none
module suote_uart
(
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic [2:0] MODE_SELECT,
  input  wire logic       TWO_WIRE_ENABLE,
  input  wire logic       CLK_SOURCE_SEL,
  input  wire logic [7:0] BAUD_DIVISOR,
  input  wire logic       BIT_ORDER_SELECT,
  input  wire logic       DATA_INVERT,
  input  wire logic       PIN_POLARITY_INVERT,
  input  wire logic       TX_ENABLE,
  input  wire logic       RX_ENABLE,
  input  wire logic [8:0] TX_DATA,
  input  wire logic       TX_WRITE,
  input  wire logic       RXD,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  input  wire logic [2:0] SDA_DELAY_SEL,
  input  wire logic       ARB_TIMING_SEL,
  input  wire logic       CLOCK_PHASE_SEL,
  output logic            TX_BUFFER_EMPTY,
  output logic            TXD,
  output logic [8:0]      RX_DATA,
  output logic            RX_VALID,
  output logic            RX_ARB_LOST,
  output logic            SDA_OUT,
  output logic            SDA_OE_N,
  output logic            START_DET,
  output logic            STOP_DET,
  output logic            ACK_DET,
  output logic            NACK_DET
);
  localparam int FRAME_W_L = suote_pkg::FRAME_W;

  logic                       src_tick;
  logic                       os_tick;
  logic                       uart_on;
  logic                       tw_on;
  logic [3:0]                 dlen;
  logic [8:0]                 tx_buf_r;
  logic                       tx_busy_r;
  logic [FRAME_W_L-1:0]       tx_sh_r;
  logic [3:0]                 tx_cnt_r;
  logic [3:0]                 tx_sub_r;
  logic                       uart_load;
  logic                       rxd_q_r;
  suote_pkg::suote_rx_state_t rx_st_r;
  logic [3:0]                 rx_sub_r;
  logic [3:0]                 rx_cnt_r;
  logic [8:0]                 rx_sh_r;
  logic                       uart_done;
  logic                       scl_q_r;
  logic                       scl_p_r;
  logic                       sda_q_r;
  logic                       sda_p_r;
  logic                       start_ev;
  logic                       stop_ev;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       tw_act_r;
  logic [3:0]                 tw_bit_r;
  logic [7:0]                 tw_rx_r;
  logic [7:0]                 tw_tx_r;
  logic                       tw_drv_r;
  logic                       pend_r;
  logic                       pend_val_r;
  logic [3:0]                 dly_r;
  logic [3:0]                 dly_nxt;
  logic                       tw_byte;
  logic                       arb_r;
  logic                       arb_set;

  // reorders and complements data; an involution, so it serves both directions
  function automatic logic [8:0] fmt(input logic [8:0] d, input logic [3:0] n,
                                     input logic msb, input logic inv);
    logic [8:0] r;
    r = d;
    if (n == suote_pkg::LEN8 && msb)
      for (int i = 0; i < 8; i++)
        r[i] = d[7 - i]; // [R2]
    if (inv && n != suote_pkg::LEN9)
      for (int i = 0; i < 9; i++)
        r[i] = (i < int'(n)) ? ~r[i] : r[i]; // [R3] [R4]
    return r;
  endfunction

  suote_baud u_baud
  (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .src_sel  (CLK_SOURCE_SEL),
    .divisor  (BAUD_DIVISOR),
    .src_tick (src_tick),
    .os_tick  (os_tick)
  );

  always_comb
  begin
    uart_on = 1'b1;
    dlen    = suote_pkg::LEN8;
    if (MODE_SELECT == suote_pkg::MODE_U7)
      dlen = suote_pkg::LEN7; // [R12]
    else if (MODE_SELECT == suote_pkg::MODE_U9)
      dlen = suote_pkg::LEN9; // [R12]
    else if (MODE_SELECT != suote_pkg::MODE_U8)
      uart_on = 1'b0;
  end

  assign tw_on     = (MODE_SELECT == suote_pkg::MODE_TW) && TWO_WIRE_ENABLE; // [R6]
  assign uart_load = uart_on && TX_ENABLE && !tx_busy_r && !TX_BUFFER_EMPTY;
  assign start_ev  = tw_on && scl_q_r && scl_p_r && sda_p_r && !sda_q_r; // [R8]
  assign stop_ev   = tw_on && scl_q_r && scl_p_r && !sda_p_r && sda_q_r; // [R8]
  assign scl_rise  = tw_on && tw_act_r && scl_q_r && !scl_p_r;
  assign scl_fall  = tw_on && tw_act_r && !scl_q_r && scl_p_r; // [R7]
  assign tw_byte   = scl_rise && (tw_bit_r == suote_pkg::TW_ACK_BIT);
  assign arb_set   = scl_rise && !tw_byte && tw_drv_r && !sda_q_r; // [R9]
  assign uart_done = os_tick && (rx_st_r == suote_pkg::RX_STOP)
                     && (rx_sub_r == suote_pkg::SUB_LAST);
  // no delay, or the selected code plus one count-source cycles; one cycle more when CLOCK_PHASE_SEL is set
  assign dly_nxt   = ((SDA_DELAY_SEL == 3'h0) ? 4'h0
                     : {1'b0, SDA_DELAY_SEL} + suote_pkg::DLY_BASE) // [R10]
                     + {3'h0, CLOCK_PHASE_SEL}; // [R11]

  // transmit buffer; a write in the same cycle as a load wins the empty flag
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_buf_r        <= 9'h000;
      TX_BUFFER_EMPTY <= 1'b1;
    end
    else if (TX_WRITE)
    begin
      tx_buf_r        <= TX_DATA;
      TX_BUFFER_EMPTY <= 1'b0;
    end
    else if (uart_load || start_ev || tw_byte)
      TX_BUFFER_EMPTY <= 1'b1;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= '0;
      tx_cnt_r  <= 4'h0;
      tx_sub_r  <= 4'h0;
    end
    else if (uart_load)
    begin
      tx_busy_r <= 1'b1;
      tx_sub_r  <= 4'h0;
      tx_cnt_r  <= dlen + suote_pkg::FRAME_XTRA;
      tx_sh_r   <= ({2'b00, fmt(tx_buf_r, dlen, BIT_ORDER_SELECT, DATA_INVERT)} << 1)
                   | (FRAME_W_L'(1) << (dlen + 4'h1)); // [R3] [R2]
    end
    else if (tx_busy_r && os_tick)
    begin
      tx_sub_r <= tx_sub_r + 4'h1;
      if (tx_sub_r == suote_pkg::SUB_LAST)
      begin
        tx_sh_r  <= tx_sh_r >> 1;
        tx_cnt_r <= tx_cnt_r - 4'h1;
        if (tx_cnt_r == 4'h1)
          tx_busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      TXD <= 1'b1;
    else
      TXD <= ((tx_busy_r && uart_on) ? tx_sh_r[0] : 1'b1) ^ PIN_POLARITY_INVERT; // [R5] [R13]
  end

  // receive line in its logical sense, framing bits included
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rxd_q_r <= 1'b1;
    else
      rxd_q_r <= RXD ^ PIN_POLARITY_INVERT; // [R5] [R13]
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_st_r  <= suote_pkg::RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_sh_r  <= 9'h000;
    end
    else if (!uart_on || !RX_ENABLE)
      rx_st_r <= suote_pkg::RX_IDLE;
    else if (os_tick)
    begin
      rx_sub_r <= rx_sub_r + 4'h1;
      case (rx_st_r)
        suote_pkg::RX_IDLE:
        begin
          rx_sub_r <= 4'h0;
          if (!rxd_q_r)
            rx_st_r <= suote_pkg::RX_START;
        end
        suote_pkg::RX_START:
          if (rx_sub_r == suote_pkg::SUB_MID) // [R15]
          begin
            rx_sub_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            rx_st_r  <= rxd_q_r ? suote_pkg::RX_IDLE : suote_pkg::RX_DATA;
          end
        suote_pkg::RX_DATA:
          if (rx_sub_r == suote_pkg::SUB_LAST) // [R15]
          begin
            rx_sh_r  <= {rxd_q_r, rx_sh_r[8:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == dlen - 4'h1)
              rx_st_r <= suote_pkg::RX_STOP;
          end
        suote_pkg::RX_STOP:
          if (rx_sub_r == suote_pkg::SUB_LAST)
            rx_st_r <= suote_pkg::RX_IDLE;
        default:
          rx_st_r <= suote_pkg::RX_IDLE;
      endcase
    end
  end

  // receive buffer is shared by both modes
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RX_DATA  <= 9'h000;
      RX_VALID <= 1'b0;
    end
    else
    begin
      RX_VALID <= uart_done || tw_byte;
      if (uart_done)
        RX_DATA <= fmt(rx_sh_r >> (suote_pkg::LEN9 - dlen), dlen,
                       BIT_ORDER_SELECT, DATA_INVERT); // [R4] [R2]
      else if (tw_byte)
        RX_DATA <= {sda_q_r, tw_rx_r};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scl_q_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= SCL_IN;
      scl_p_r <= scl_q_r;
      sda_q_r <= SDA_IN;
      sda_p_r <= sda_q_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tw_act_r <= 1'b0;
      tw_bit_r <= 4'h0;
      tw_rx_r  <= 8'h00;
      tw_tx_r  <= suote_pkg::TW_IDLE_TX;
    end
    else if (!tw_on || stop_ev)
      tw_act_r <= 1'b0;
    else if (start_ev || tw_byte)
    begin
      tw_act_r <= 1'b1;
      tw_bit_r <= 4'h0;
      tw_tx_r  <= TX_BUFFER_EMPTY ? suote_pkg::TW_IDLE_TX : tx_buf_r[7:0];
    end
    else if (scl_rise)
    begin
      tw_rx_r  <= {tw_rx_r[6:0], sda_q_r};
      tw_bit_r <= tw_bit_r + 4'h1;
    end
    else if (scl_fall && tw_bit_r != suote_pkg::TW_ACK_BIT)
      tw_tx_r <= {tw_tx_r[6:0], 1'b1};
  end

  // the new SDA level waits out the selected delay after SCL is seen low
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pend_r     <= 1'b0;
      pend_val_r <= 1'b1;
      dly_r      <= 4'h0;
      tw_drv_r   <= 1'b1;
    end
    else if (!tw_on || stop_ev)
    begin
      pend_r   <= 1'b0;
      tw_drv_r <= 1'b1;
    end
    else if (scl_fall)
    begin
      pend_r     <= 1'b1; // [R7]
      pend_val_r <= (tw_bit_r == suote_pkg::TW_ACK_BIT) ? 1'b1 : tw_tx_r[7];
      dly_r      <= dly_nxt; // [R10] [R11]
    end
    else if (pend_r)
    begin
      if (dly_r == 4'h0)
      begin
        pend_r   <= 1'b0;
        tw_drv_r <= pend_val_r; // [R7]
      end
      else if (src_tick)
        dly_r <= dly_r - 4'h1; // [R10]
    end
  end

  // arbitration flag: cleared by a start, a loss in that cycle still wins
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      arb_r       <= 1'b0;
      RX_ARB_LOST <= 1'b0;
    end
    else
    begin
      if (arb_set)
        arb_r <= 1'b1; // [R9]
      else if (start_ev)
        arb_r <= 1'b0;
      if (!ARB_TIMING_SEL)
        RX_ARB_LOST <= arb_r; // [R9]
      else if (tw_byte)
        RX_ARB_LOST <= arb_r; // [R9]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SDA_OUT   <= 1'b0;
      SDA_OE_N  <= 1'b1;
      START_DET <= 1'b0;
      STOP_DET  <= 1'b0;
      ACK_DET   <= 1'b0;
      NACK_DET  <= 1'b0;
    end
    else
    begin
      // open drain: only a low is ever driven
      SDA_OUT   <= 1'b0;
      SDA_OE_N  <= !(tw_on && !tw_drv_r);
      START_DET <= start_ev; // [R8]
      STOP_DET  <= stop_ev; // [R8]
      ACK_DET   <= tw_byte && !sda_q_r; // [R8]
      NACK_DET  <= tw_byte && sda_q_r; // [R8]
    end
  end
endmodule
`default_nettype wire

// file: test/suote_uart_asserts.sv
// port-level checker for the serial channel
// assumes one clock, CORE_CLK, and an asynchronous active-low RST_N
`default_nettype none
module suote_asserts
(
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic [2:0] MODE_SELECT,
  input wire logic       TWO_WIRE_ENABLE,
  input wire logic       ARB_TIMING_SEL,
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic [8:0] RX_DATA,
  input wire logic       RX_VALID,
  input wire logic       RX_ARB_LOST,
  input wire logic       SDA_OE_N,
  input wire logic       START_DET,
  input wire logic       STOP_DET,
  input wire logic       ACK_DET,
  input wire logic       NACK_DET
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  logic       tw_on;
  logic [1:0] rv_r;
  assign tw_on = (MODE_SELECT == suote_pkg::MODE_TW) && TWO_WIRE_ENABLE;
  always_ff @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N)
      rv_r <= 2'h0;
    else
      rv_r <= {rv_r[0], RX_VALID};
  // the far side holds each level well over five cycles
  sequence s_start;
    SCL_IN && !SDA_IN && $past(SDA_IN, 5);
  endsequence
  sequence s_stop;
    SCL_IN && SDA_IN && !$past(SDA_IN, 5);
  endsequence
  sequence s_byte_end;
    (RX_VALID || rv_r != 2'h0) or (##[1:2] RX_VALID);
  endsequence
  a_start_gate: assert property (START_DET |-> $past(tw_on))
    else $error("start event outside two-wire mode");
  // the output register lags the mode by one cycle
  a_sda_gate: assert property (!SDA_OE_N |-> $past(tw_on))
    else $error("SDA driven outside two-wire mode");
  a_sda_scl_low: assert property ($fell(SDA_OE_N) |-> !SCL_IN)
    else $error("SDA pulled low while SCL high");
  a_start_cause: assert property (START_DET |-> s_start)
    else $error("start event without start condition");
  a_stop_cause: assert property (STOP_DET |-> s_stop)
    else $error("stop event without stop condition");
  a_stop_release: assert property (STOP_DET |-> ##[0:2] SDA_OE_N)
    else $error("SDA not released after stop");
  a_ack_bit: assert property (ACK_DET |-> ##[0:1] !RX_DATA[8])
    else $error("ack event with ack bit high");
  a_nack_bit: assert property (NACK_DET |-> ##[0:1] RX_DATA[8])
    else $error("nack event with ack bit low");
  a_arb_byte_end: assert property ($rose(RX_ARB_LOST) && ARB_TIMING_SEL |-> s_byte_end)
    else $error("arbitration flag moved away from byte end");
  a_valid_pulse: assert property (RX_VALID |=> !RX_VALID)
    else $error("receive strobe longer than one cycle");
endmodule
bind suote_uart suote_asserts i_suote_asserts (.CORE_CLK, .RST_N, .MODE_SELECT,
  .TWO_WIRE_ENABLE, .ARB_TIMING_SEL, .SCL_IN, .SDA_IN, .RX_DATA, .RX_VALID,
  .RX_ARB_LOST, .SDA_OE_N, .START_DET, .STOP_DET, .ACK_DET, .NACK_DET);
`default_nettype wire

// file: test/suote_peer.sv
// far-side model: serial sender on RXD and a two-wire master on SCL/SDA
// assumes SDA has a pull-up, so a released line reads high
`default_nettype none
module suote_peer
(
  input  wire logic CORE_CLK,
  input  wire logic SDA_OE_N,
  input  wire logic SDA_OUT,
  output logic      RXD,
  output logic      SCL_IN,
  output logic      SDA_IN
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 20;
  logic psda;
  int   dly_seen;
  assign SDA_IN = psda & (SDA_OE_N | SDA_OUT);
  initial
  begin
    RXD = 1'h1;
    SCL_IN = 1'h1;
    psda = 1'h1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic send(input logic [10:0] f, input int n, input int t);
    for (int i = 0; i < n; i++)
    begin
      RXD = f[i];
      hold(t);
    end
  endtask
  // pb: data in [8:1], acknowledge in [0]; clock low time covers the longest delay
  task automatic xfer(input logic [8:0] pb);
    hold(HALF);
    psda = 1'h0;
    hold(HALF);
    SCL_IN = 1'h0;
    dly_seen = 0;
    while (SDA_OE_N && dly_seen < HALF)
    begin
      hold(1);
      dly_seen++;
    end
    hold(HALF - dly_seen);
    for (int i = 8; i >= 0; i--)
    begin
      psda = pb[i];
      hold(HALF);
      SCL_IN = 1'h1;
      hold(HALF);
      SCL_IN = 1'h0;
      hold(HALF);
    end
  endtask
  task automatic stop;
    psda = 1'h0;
    hold(HALF);
    SCL_IN = 1'h1;
    hold(HALF);
    psda = 1'h1;
    hold(HALF);
  endtask
endmodule
`default_nettype wire

// file: test/suote_uart_tb.sv
// self-checking bench for the serial channel
// assumes the far side is modelled by suote_peer
`default_nettype none
module suote_uart_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CORE_CLK, RST_N, TWO_WIRE_ENABLE, CLK_SOURCE_SEL, BIT_ORDER_SELECT;
  logic       DATA_INVERT, PIN_POLARITY_INVERT, TX_ENABLE, RX_ENABLE, TX_WRITE, RXD;
  logic       SCL_IN, SDA_IN, ARB_TIMING_SEL, CLOCK_PHASE_SEL, TX_BUFFER_EMPTY, TXD;
  logic       RX_VALID, RX_ARB_LOST, SDA_OUT, SDA_OE_N, START_DET, STOP_DET;
  logic       ACK_DET, NACK_DET;
  logic [2:0] MODE_SELECT, SDA_DELAY_SEL;
  logic [7:0] BAUD_DIVISOR;
  logic [8:0] TX_DATA, RX_DATA;
  int         fails, comparisons, n_st, n_sp, n_ak, n_nk, n_rv, n_tx;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
  suote_uart i_suote_uart (.CORE_CLK, .RST_N, .MODE_SELECT, .TWO_WIRE_ENABLE,
    .CLK_SOURCE_SEL, .BAUD_DIVISOR, .BIT_ORDER_SELECT, .DATA_INVERT,
    .PIN_POLARITY_INVERT, .TX_ENABLE, .RX_ENABLE, .TX_DATA, .TX_WRITE, .RXD,
    .SCL_IN, .SDA_IN, .SDA_DELAY_SEL, .ARB_TIMING_SEL, .CLOCK_PHASE_SEL,
    .TX_BUFFER_EMPTY, .TXD, .RX_DATA, .RX_VALID, .RX_ARB_LOST, .SDA_OUT,
    .SDA_OE_N, .START_DET, .STOP_DET, .ACK_DET, .NACK_DET);
  suote_peer i_peer (.CORE_CLK, .SDA_OE_N, .SDA_OUT, .RXD, .SCL_IN, .SDA_IN);
  function automatic logic [10:0] frame(input logic [8:0] w, input int n,
                                        input logic msb, input logic di,
                                        input logic pi);
    logic [8:0] d;
    frame = 11'h0;
    d = (di && n != 9) ? ~w : w;
    for (int i = 0; i < n; i++)
      frame[i + 1] = msb ? d[n - 1 - i] : d[i];
    frame[n + 1] = 1'h1;
    frame = frame ^ ({11{pi}} & ((11'h1 << (n + 2)) - 11'h1));
  endfunction
  task automatic stop_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [8:0] v);
    TX_DATA = v;
    TX_WRITE = 1'h1;
    i_peer.hold(1);
    TX_WRITE = 1'h0;
  endtask
  initial
  begin
    CORE_CLK = 1'h0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK)
  begin
    n_st += START_DET;
    n_sp += STOP_DET;
    n_ak += ACK_DET;
    n_nk += NACK_DET;
    n_rv += RX_VALID;
    n_tx += !TXD;
  end
  // longest run: six frames at the slowest bit time, three at the fastest, plus the two-wire bytes
  initial
  begin
    i_peer.hold(80000);
    fails++;
    stop_test();
  end
  initial
  begin
    logic [10:0] got;
    logic [8:0]  w_tx, w_rx, rx, mask, pb;
    logic [7:0]  txb;
    logic        msb, di, pi, src;
    int          len, div, t, lo;
    {RST_N, TWO_WIRE_ENABLE, CLK_SOURCE_SEL, BIT_ORDER_SELECT, DATA_INVERT} = 5'h0;
    {PIN_POLARITY_INVERT, TX_WRITE, ARB_TIMING_SEL, CLOCK_PHASE_SEL} = 4'h0;
    {TX_ENABLE, RX_ENABLE} = 2'h3;
    {MODE_SELECT, SDA_DELAY_SEL, BAUD_DIVISOR, TX_DATA} = 23'h0;
    void'($urandom(10336));
    i_peer.hold(4);
    RST_N = 1'h1;
    `CHK(TXD, 1'h1)
    for (int k = 0; k < 9; k++)
    begin
      len = 7 + k % 3;
      w_tx = 9'($urandom);
      w_rx = 9'($urandom);
      div = (k < 3) ? 0 : $urandom_range(0, 3);
      src = (k < 3) ? 1'h0 : 1'($urandom);
      di = (k < 3) || 1'($urandom);
      pi = (k < 3) || 1'($urandom);
      msb = (len == 8) && ((k < 3) || 1'($urandom));
      MODE_SELECT = suote_pkg::MODE_U7 + 3'(k % 3);
      {BAUD_DIVISOR, CLK_SOURCE_SEL} = {8'(div), src};
      {BIT_ORDER_SELECT, DATA_INVERT, PIN_POLARITY_INVERT} = {msb, di, pi};
      i_peer.RXD = !pi;
      i_peer.hold(40);
      t = 16 * (div + 1) * (src ? 8 : 1);
      got = 11'h0;
      rx = 9'h0;
      wr(w_tx);
      `CHK(TX_BUFFER_EMPTY, 1'h0)
      fork
        i_peer.send(frame(w_rx, len, msb, di, pi), len + 2, t);
        begin
          for (int m = 0; TXD !== pi && m < 100; m++)
            i_peer.hold(1);
          i_peer.hold(t / 2);
          for (int i = 0; i < len + 2; i++)
          begin
            got[i] = TXD;
            i_peer.hold(t);
          end
        end
        begin
          for (int m = 0; RX_VALID !== 1'h1 && m < 12 * t; m++)
            i_peer.hold(1);
          rx = RX_DATA;
        end
      join
      mask = (9'h1 << len) - 9'h1;
      `CHK(got, frame(w_tx, len, msb, di, pi))
      `CHK(rx & mask, w_rx & mask)
      `CHK(TX_BUFFER_EMPTY, 1'h1)
    end
    // with both directions disabled a frame on the line and a buffered word stay put
    {MODE_SELECT, BAUD_DIVISOR, CLK_SOURCE_SEL} = {suote_pkg::MODE_U8, 9'h0};
    {BIT_ORDER_SELECT, DATA_INVERT, PIN_POLARITY_INVERT, TX_ENABLE, RX_ENABLE} = 5'h0;
    i_peer.RXD = 1'h1;
    i_peer.hold(40);
    {n_rv, n_tx} = 0;
    wr(w_tx);
    i_peer.send(frame(w_rx, 8, 1'h0, 1'h0, 1'h0), 10, 16);
    i_peer.hold(40);
    `CHK(n_rv, 0)
    `CHK({n_tx, TX_BUFFER_EMPTY}, {32'd0, 1'h0})
    {MODE_SELECT, PIN_POLARITY_INVERT, CLK_SOURCE_SEL} = {suote_pkg::MODE_TW, 2'h0};
    {TX_ENABLE, RX_ENABLE} = 2'h3;
    i_peer.RXD = 1'h1;
    {n_st, n_sp} = 0;
    i_peer.xfer(9'h1ff);
    i_peer.stop();
    `CHK(n_st + n_sp, 0)
    TWO_WIRE_ENABLE = 1'h1;
    for (int k = 0; k < 8; k++)
    begin
      {SDA_DELAY_SEL, CLOCK_PHASE_SEL, ARB_TIMING_SEL} = {3'(k), k[1], 1'($urandom)};
      txb = (8'($urandom) & 8'h7f) | 8'h01;
      pb = {k[0] ? txb & 8'hfe : 8'hff, 1'($urandom)};
      wr({1'h0, txb});
      {n_st, n_sp, n_ak, n_nk} = 0;
      i_peer.xfer(pb);
      lo = (k != 0 ? k + 1 : 0) + int'(k[1]);
      `CHK(RX_DATA, {pb[0], txb & pb[8:1]})
      `CHK(RX_ARB_LOST, k[0])
      `CHK({n_st, n_ak, n_nk}, {32'd1, int'(!pb[0]), int'(pb[0])})
      `CHK(i_peer.dly_seen >= lo && i_peer.dly_seen <= lo + 5, 1'h1)
      `CHK({TX_BUFFER_EMPTY, SDA_OUT}, 2'h2)
      i_peer.stop();
      `CHK(n_sp, 1)
    end
    stop_test();
  end
endmodule
`default_nettype wire
